//--- design/timer_capture.sv
`timescale 1ns/10ps
module timer_capture (
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset_n,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_write,
    input  wire logic       i_read,
    output logic      [7:0] o_rdata,
    input  wire logic       i_enable,
    input  wire logic [2:0] i_timer_mode_field,
    input  wire logic       i_edge_select,
    input  wire logic       i_sample_event_input_enable,
    input  wire logic       i_event,
    input  wire logic       i_debug_halted,
    output logic            o_interrupt_request,
    output logic            o_wrap_event
);
    logic [7:0]  interrupt_enable;
    logic [7:0]  interrupt_flags;
    logic [7:0]  debug_halt_control;
    logic [7:0]  shared_byte_buffer;
    logic [15:0] counter_value;
    logic [15:0] compare_capture_value;
    logic        running;
    logic [7:0]  read_byte;
    timer_capture_pkg::freq_pw_state_type fp_state;
    timer_capture_pkg::freq_pw_state_type next_fp_state;

    wire halted     = i_debug_halted & ~debug_halt_control[timer_capture_pkg::bit_run_while_halted];
    wire active     = i_enable & ~halted;
    wire rise;
    wire fall;

    // events pass only while enabled and not held by the debugger
    event_edge_detect edge_unit (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_event   (i_event),
        .i_enable  (i_sample_event_input_enable & active),
        .o_rise    (rise),
        .o_fall    (fall)
    );

    // edge select swaps which edge is primary
    wire primary   = i_edge_select ? fall : rise;
    wire secondary = i_edge_select ? rise : fall;

    // one decoded line per mode code
    wire [7:0] mode_hit;
    genvar mode_idx;
    generate
        for (mode_idx = 0; mode_idx < 8; mode_idx = mode_idx + 1) begin : mode_cell
            assign mode_hit[mode_idx] = i_timer_mode_field == 3'(mode_idx);
        end
    endgenerate

    wire m_periodic = mode_hit[timer_capture_pkg::mode_periodic];
    wire m_timeout  = mode_hit[timer_capture_pkg::mode_timeout];
    wire m_capture  = mode_hit[timer_capture_pkg::mode_capture];
    wire m_freq     = mode_hit[timer_capture_pkg::mode_frequency];
    wire m_pulse    = mode_hit[timer_capture_pkg::mode_pulse];
    wire m_freq_pw  = mode_hit[timer_capture_pkg::mode_freq_pw];
    wire m_single   = mode_hit[timer_capture_pkg::mode_single];
    wire m_pwm8     = mode_hit[timer_capture_pkg::mode_pwm8];
    wire m_top16    = m_periodic | m_timeout | m_single;
    wire m_sample_interrupt_any = m_capture | m_freq | m_pulse | m_freq_pw;

    // register decode, one hit line per offset
    wire [15:0] addr_hit;
    genvar addr_idx;
    generate
        for (addr_idx = 0; addr_idx < 16; addr_idx = addr_idx + 1) begin : addr_cell
            assign addr_hit[addr_idx] = i_addr == 4'(addr_idx);
        end
    endgenerate

    wire wr_enable   = i_write & addr_hit[timer_capture_pkg::off_interrupt_enable];
    wire wr_flags    = i_write & addr_hit[timer_capture_pkg::off_interrupt_flags];
    wire wr_debug    = i_write & addr_hit[timer_capture_pkg::off_debug_halt];
    wire wr_shared   = i_write & addr_hit[timer_capture_pkg::off_shared_byte];
    wire wr_cnt_low  = i_write & addr_hit[timer_capture_pkg::off_counter_low];
    wire wr_cnt_high = i_write & addr_hit[timer_capture_pkg::off_counter_high];
    wire wr_cmp_low  = i_write & addr_hit[timer_capture_pkg::off_compare_low];
    wire wr_cmp_high = i_write & addr_hit[timer_capture_pkg::off_compare_high];
    wire rd_cnt_low  = i_read & addr_hit[timer_capture_pkg::off_counter_low];
    wire rd_cmp_low  = i_read & addr_hit[timer_capture_pkg::off_compare_low];
    wire rd_cmp_high = i_read & addr_hit[timer_capture_pkg::off_compare_high];
    wire capture_read = rd_cmp_low | rd_cmp_high;

    // pwm8 byte writes go straight in, since the bytes act as separate registers
    wire pwm_low_direct  = m_pwm8 & wr_cmp_low;
    wire pwm_high_direct = m_pwm8 & wr_cmp_high;

    wire [15:0] top_value = m_pwm8 ? {8'h00, compare_capture_value[7:0]} : compare_capture_value;
    wire at_top    = counter_value == top_value;
    wire at_duty   = m_pwm8 & (counter_value[7:0] == compare_capture_value[15:8]);

    // timeout: primary starts, secondary stops; single: start on rise, or on either edge when edge select is set
    wire single_start = m_single & (i_edge_select ? (rise | fall) : rise);
    wire start_evt    = (m_timeout & primary) | single_start;
    wire stop_evt     = m_timeout & secondary & running;

    wire fp_capture   = m_freq_pw & (fp_state == timer_capture_pkg::fp_active) & secondary;
    wire fp_finish    = m_freq_pw & (fp_state == timer_capture_pkg::fp_active) & primary;
    wire fp_restart   = m_freq_pw & (fp_state == timer_capture_pkg::fp_idle) & primary;

    wire capture_evt  = (m_capture & primary)
                      | (m_freq & primary)
                      | (m_pulse & secondary)
                      | fp_capture;
    wire restart_evt  = (m_freq & primary) | (m_pulse & primary) | fp_restart;

    // restart or top match owns the cycle, so no wrap flag then
    wire count_now    = active & running;
    wire top_hit      = count_now & (m_top16 | m_pwm8) & at_top;
    wire wrap_hit     = count_now & ~top_hit & (counter_value == timer_capture_pkg::max_count) & ~restart_evt;

    wire set_sample = (top_hit & m_top16)
                    | (count_now & at_duty)
                    | (m_sample_interrupt_any & (capture_evt & ~fp_capture))
                    | fp_finish;
    wire set_wrap   = wrap_hit;

    wire clr_sample = (wr_flags & i_wdata[timer_capture_pkg::bit_sample_interrupt])
                    | (m_sample_interrupt_any & capture_read);
    wire clr_wrap   = wr_flags & i_wdata[timer_capture_pkg::bit_wrap_interrupt];

    // one set/clear cell per flag bit; set wins so an event in the clearing cycle is kept
    wire [1:0] flag_set;
    wire [1:0] flag_clear;
    wire [1:0] next_flags;
    wire [1:0] irq_source;
    assign flag_set[timer_capture_pkg::bit_sample_interrupt]   = set_sample;
    assign flag_set[timer_capture_pkg::bit_wrap_interrupt]     = set_wrap;
    assign flag_clear[timer_capture_pkg::bit_sample_interrupt] = clr_sample;
    assign flag_clear[timer_capture_pkg::bit_wrap_interrupt]   = clr_wrap;
    genvar flag_idx;
    generate
        for (flag_idx = 0; flag_idx < 2; flag_idx = flag_idx + 1) begin : flag_cell
            assign next_flags[flag_idx] = flag_set[flag_idx] | (interrupt_flags[flag_idx] & ~flag_clear[flag_idx]);
            assign irq_source[flag_idx] = interrupt_enable[flag_idx] & interrupt_flags[flag_idx];
        end
    endgenerate

    // both 16-bit commits pair the written high byte with the staged low byte
    wire [15:0] staged_word   = {i_wdata, shared_byte_buffer};
    wire [15:0] pwm_low_word  = {compare_capture_value[15:8], i_wdata};
    wire [15:0] pwm_high_word = {i_wdata, compare_capture_value[7:0]};

    // counter next value: external write first, then restart, top, count
    wire [15:0] counted = counter_value + 16'h0001;
    wire [15:0] next_counter =
          wr_cnt_high              ? staged_word
        : restart_evt              ? timer_capture_pkg::reset_word
        : top_hit                  ? timer_capture_pkg::reset_word
        : count_now                ? counted
        : counter_value;

    // single-shot and timeout stop at top; freq plus pulse stops on finish
    wire run_free  = m_periodic | m_capture | m_freq | m_pulse | m_pwm8;
    wire run_fp    = ((fp_state == timer_capture_pkg::fp_active) & ~fp_finish) | fp_restart;
    wire run_stop  = stop_evt | (top_hit & (m_single | m_timeout));
    wire run_gated = start_evt | (running & ~run_stop);

    wire next_running =
          ~i_enable ? 1'b0
        : run_free  ? 1'b1
        : m_freq_pw ? run_fp
        : run_gated;

    always_comb begin
        next_fp_state = fp_state;
        case (fp_state)
            timer_capture_pkg::fp_idle: begin
                if (fp_restart) begin
                    next_fp_state = timer_capture_pkg::fp_active;
                end
            end
            timer_capture_pkg::fp_active: begin
                if (fp_finish) begin
                    next_fp_state = timer_capture_pkg::fp_done;
                end
            end
            timer_capture_pkg::fp_done: begin
                // rearm once software has read the capture or cleared the flag
                if (~interrupt_flags[timer_capture_pkg::bit_sample_interrupt]) begin
                    next_fp_state = timer_capture_pkg::fp_idle;
                end
            end
            default: begin
                next_fp_state = timer_capture_pkg::fp_idle;
            end
        endcase
        if (~m_freq_pw | ~i_enable) begin
            next_fp_state = timer_capture_pkg::fp_idle;
        end
    end

    // compare register: capture beats a same-cycle software write
    wire [15:0] next_compare =
          capture_evt     ? counter_value
        : pwm_low_direct  ? pwm_low_word
        : pwm_high_direct ? pwm_high_word
        : wr_cmp_high     ? staged_word
        : compare_capture_value;

    // shared byte: staged by low writes, loaded by low reads, or written directly
    wire [7:0] next_shared =
          wr_shared                      ? i_wdata
        : wr_cnt_low                     ? i_wdata
        : (wr_cmp_low & ~m_pwm8)         ? i_wdata
        : rd_cnt_low                     ? counter_value[15:8]
        : (rd_cmp_low & ~m_pwm8)         ? compare_capture_value[15:8]
        : shared_byte_buffer;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            interrupt_enable <= timer_capture_pkg::reset_byte;
        end else if (wr_enable) begin
            interrupt_enable <= {6'h00, i_wdata[1:0]};
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            debug_halt_control <= timer_capture_pkg::reset_byte;
        end else if (wr_debug) begin
            debug_halt_control <= {7'h00, i_wdata[0]};
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            interrupt_flags <= timer_capture_pkg::reset_byte;
        end else begin
            interrupt_flags <= {6'h00, next_flags};
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            counter_value <= timer_capture_pkg::reset_word;
        end else begin
            counter_value <= next_counter;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            compare_capture_value <= timer_capture_pkg::reset_word;
        end else begin
            compare_capture_value <= next_compare;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            shared_byte_buffer <= timer_capture_pkg::reset_byte;
        end else begin
            shared_byte_buffer <= next_shared;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            running <= 1'b0;
        end else begin
            running <= next_running;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fp_state <= timer_capture_pkg::fp_idle;
        end else begin
            fp_state <= next_fp_state;
        end
    end

    // status is read-only: no write path exists, so a bus write cannot set it
    wire [7:0] status_byte = {7'h00, running};

    // read mux; high bytes of 16-bit registers come from the shared byte, except compare high in pwm8 mode
    always_comb begin
        case (i_addr)
            timer_capture_pkg::off_interrupt_enable: read_byte = interrupt_enable;
            timer_capture_pkg::off_interrupt_flags:  read_byte = interrupt_flags;
            timer_capture_pkg::off_run_status:       read_byte = status_byte;
            timer_capture_pkg::off_debug_halt:       read_byte = debug_halt_control;
            timer_capture_pkg::off_shared_byte:      read_byte = shared_byte_buffer;
            timer_capture_pkg::off_counter_low:      read_byte = counter_value[7:0];
            timer_capture_pkg::off_counter_high:     read_byte = shared_byte_buffer;
            timer_capture_pkg::off_compare_low:      read_byte = compare_capture_value[7:0];
            timer_capture_pkg::off_compare_high:     read_byte = m_pwm8 ? compare_capture_value[15:8]
                                                                        : shared_byte_buffer;
            default:                                 read_byte = 8'h00;
        endcase
    end

    // read data registered: valid the cycle after the read strobe
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 8'h00;
        end else if (i_read) begin
            o_rdata <= read_byte;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_wrap_event <= 1'b0;
        end else begin
            o_wrap_event <= set_wrap;
        end
    end

    assign o_interrupt_request =
          irq_source[timer_capture_pkg::bit_wrap_interrupt]
        | irq_source[timer_capture_pkg::bit_sample_interrupt];
endmodule

//--- design/timer_capture_pkg.sv
package timer_capture_pkg;
    localparam logic [3:0] off_interrupt_enable = 4'h5;
    localparam logic [3:0] off_interrupt_flags  = 4'h6;
    localparam logic [3:0] off_run_status       = 4'h7;
    localparam logic [3:0] off_debug_halt       = 4'h8;
    localparam logic [3:0] off_shared_byte      = 4'h9;
    localparam logic [3:0] off_counter_low      = 4'ha;
    localparam logic [3:0] off_counter_high     = 4'hb;
    localparam logic [3:0] off_compare_low      = 4'hc;
    localparam logic [3:0] off_compare_high     = 4'hd;
    localparam int bit_sample_interrupt = 0;
    localparam int bit_wrap_interrupt   = 1;
    localparam int bit_run              = 0;
    localparam int bit_run_while_halted = 0;
    localparam logic [7:0]  reset_byte  = 8'h00;
    localparam logic [15:0] reset_word  = 16'h0000;
    localparam logic [15:0] max_count   = 16'hffff;
    localparam logic [2:0] mode_periodic  = 3'h0;
    localparam logic [2:0] mode_timeout   = 3'h1;
    localparam logic [2:0] mode_capture   = 3'h2;
    localparam logic [2:0] mode_frequency = 3'h3;
    localparam logic [2:0] mode_pulse     = 3'h4;
    localparam logic [2:0] mode_freq_pw   = 3'h5;
    localparam logic [2:0] mode_single    = 3'h6;
    localparam logic [2:0] mode_pwm8      = 3'h7;
    typedef enum logic [2:0] {
        fp_idle   = 3'b001,
        fp_active = 3'b010,
        fp_done   = 3'b100
    } freq_pw_state_type;
endpackage

//--- design/event_edge_detect.sv
`timescale 1ns/10ps
module event_edge_detect (
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    input  wire logic i_event,
    input  wire logic i_enable,
    output logic      o_rise,
    output logic      o_fall
);
    logic last_level;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            last_level <= 1'b0;
        end else begin
            last_level <= i_event;
        end
    end

    // the previous level keeps tracking while disabled so no stale edge appears on re-enable
    assign o_rise = i_enable & i_event & ~last_level;
    assign o_fall = i_enable & ~i_event & last_level;
endmodule

//--- tb/timer_capture_props.sv
`timescale 1ns/10ps
module timer_capture_props (
    input wire logic       i_clk_sys,
    input wire logic       i_reset_n,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_write,
    input wire logic       i_read,
    input wire logic [7:0] o_rdata,
    input wire logic       o_interrupt_request,
    input wire logic       o_wrap_event
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    wrap_single_pulse_a: assert property (o_wrap_event |=> !o_wrap_event)
        else $error("wrap pulse longer than one cycle");
    unmapped_read_zero_a: assert property (i_read && (i_addr < 4'h5 || i_addr > 4'hd) |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    run_status_bits_a: assert property (i_read && i_addr == timer_capture_pkg::off_run_status
        |=> o_rdata[7:1] == 7'h00) else $error("run status upper bits set");
    rdata_hold_a: assert property (!i_read |=> $stable(o_rdata))
        else $error("read data changed without read");
    shared_byte_rw_a: assert property (i_write && i_addr == timer_capture_pkg::off_shared_byte ##2 !i_write
        && i_read && i_addr == timer_capture_pkg::off_shared_byte |=> o_rdata == $past(i_wdata, 3))
        else $error("shared byte readback wrong");
    low_write_stage_a: assert property (i_write && i_addr == timer_capture_pkg::off_counter_low ##2 !i_write
        && i_read && i_addr == timer_capture_pkg::off_shared_byte |=> o_rdata == $past(i_wdata, 3))
        else $error("low byte not staged");
    enable_readback_a: assert property (i_write && i_addr == timer_capture_pkg::off_interrupt_enable ##2 !i_write
        && i_read && i_addr == timer_capture_pkg::off_interrupt_enable
        |=> o_rdata[1:0] == $past(i_wdata[1:0], 3)) else $error("enable readback wrong");
    irq_masked_a: assert property (i_write && i_addr == timer_capture_pkg::off_interrupt_enable
        && i_wdata[1:0] == 2'b00 |=> !o_interrupt_request) else $error("irq with enables clear");
endmodule

//--- tb/event_source.sv
`timescale 1ns/10ps
module event_source (
    input  wire logic       i_clk_sys,
    input  wire logic       i_start,
    input  wire logic [3:0] i_count,
    input  wire logic [7:0] i_width,
    output logic            o_event,
    output logic            o_busy
);
    logic [3:0] edges = 4'h0;
    logic [7:0] hold  = 8'h00;
    initial o_event = 1'b0;
    assign o_busy = edges != 4'h0;
    // level changes at the edge, wide gaps model a slow network
    always @(posedge i_clk_sys) begin
        if (i_start) begin
            edges <= i_count;
            hold  <= i_width;
        end else if (edges != 4'h0 && hold == 8'h00) begin
            o_event <= !o_event;
            edges   <= edges - 4'h1;
            hold    <= i_width;
        end else if (edges != 4'h0) begin
            hold <= hold - 8'h01;
        end
    end
endmodule

//--- tb/tb.sv
`timescale 1ns/10ps
module tb;
    logic i_clk_sys, i_reset_n, i_write, i_read, i_enable, i_edge_select, i_sample_event_input_enable;
    logic i_debug_halted, o_interrupt_request, o_wrap_event, i_event, ev_start, ev_busy;
    logic [3:0]  i_addr, ev_count;
    logic [7:0]  i_wdata, o_rdata, ev_width, b;
    logic [2:0]  i_timer_mode_field;
    logic [15:0] v, w, w2;
    int seed = 32'h7a8c;
    int err_count = 0;
    int num_checks = 0;
    timer_capture timer_capture_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_enable(i_enable),
        .i_timer_mode_field(i_timer_mode_field), .i_edge_select(i_edge_select),
        .i_sample_event_input_enable(i_sample_event_input_enable), .i_event(i_event),
        .i_debug_halted(i_debug_halted), .o_interrupt_request(o_interrupt_request), .o_wrap_event(o_wrap_event));
    event_source event_source_i (.i_clk_sys(i_clk_sys), .i_start(ev_start), .i_count(ev_count),
        .i_width(ev_width), .o_event(i_event), .o_busy(ev_busy));
    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = !i_clk_sys;
    end
    task automatic final_report();
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge i_clk_sys);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_addr = a;
        i_wdata = d;
        i_write = 1'b1;
        tick();
        i_write = 1'b0;
        tick();
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        i_addr = a;
        i_read = 1'b1;
        tick();
        i_read = 1'b0;
        d = o_rdata;
        tick();
    endtask
    task automatic wr16(input logic [3:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(a + 4'h1, d[15:8]);
    endtask
    task automatic rd16(input logic [3:0] a, output logic [15:0] d);
        rd(a, d[7:0]);
        rd(a + 4'h1, d[15:8]);
    endtask
    // start a burst of c level changes, each held w+1 cycles, then let the timer settle
    task automatic burst(input logic [3:0] c, input logic [7:0] w);
        ev_count = c;
        ev_width = w;
        ev_start = 1'b1;
        tick();
        ev_start = 1'b0;
        for (int n = 0; n < 200 && ev_busy; n++) tick();
        repeat (30) tick();
    endtask
    initial begin
        {i_reset_n, i_write, i_read, i_enable, i_edge_select, i_sample_event_input_enable} = 6'h00;
        {i_debug_halted, ev_start, i_addr, i_wdata, i_timer_mode_field, ev_count, ev_width} = 32'h0;
        repeat (16) @(posedge i_clk_sys);
        #1 i_reset_n = 1'b1;
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0], b);
            chk(b, 16'h0000);
        end
        b = 8'($random(seed));
        wr(4'h9, b);
        rd(4'h9, w[7:0]);
        chk(w[7:0], b);
        v = 16'($random(seed));
        wr(4'ha, v[7:0]);
        rd(4'h9, b);
        chk(b, v[7:0]);
        wr(4'hb, v[15:8]);
        rd16(4'ha, w);
        chk(w, v);
        wr(4'h7, 8'hff);
        rd(4'h7, b);
        chk(b, 16'h0000);
        wr(4'h5, 8'h03);
        rd(4'h5, b);
        chk(b[1:0], 16'h0003);
        i_sample_event_input_enable = 1'b1;
        for (int m = 0; m < 16; m++) begin
            i_enable = 1'b0;
            i_timer_mode_field = m[3:1];
            i_edge_select = m[0];
            wr16(4'hc, m[3:1] == 3'h7 ? 16'h0308 : 16'h0008);
            wr16(4'ha, 16'h0000);
            wr(4'h6, 8'h03);
            i_enable = 1'b1;
            tick();
            rd(4'h7, b);
            chk(b[0], m[3:1] != 3'h1 && m[3:1] != 3'h5 && m[3:1] != 3'h6);
            burst(4'h4, 8'h0c);
            rd(4'h6, b);
            chk(b[0], 16'h0001);
            chk(o_interrupt_request, 16'h0001);
        end
        i_enable = 1'b0;
        i_timer_mode_field = 3'h2;
        v = 16'($random(seed) & 32'h7fff);
        wr16(4'ha, v);
        wr(4'h6, 8'h03);
        i_enable = 1'b1;
        burst(4'h2, 8'($random(seed) & 32'h0f));
        rd(4'h6, b);
        chk(b[0], 16'h0001);
        rd16(4'hc, w);
        chk(w - v < 16'd300, 16'h0001);
        rd(4'h6, b);
        chk(b[0], 16'h0000);
        for (int g = 0; g < 3; g++) begin
            i_sample_event_input_enable = g != 0;
            i_debug_halted = g != 0;
            wr(4'h8, g == 2);
            wr(4'h6, 8'h03);
            burst(4'h2, 8'h04);
            rd(4'h6, b);
            chk(b[0], g == 2);
            rd16(4'ha, w);
            rd16(4'ha, w2);
            chk(w2 === w, g == 1);
        end
        {i_debug_halted, i_sample_event_input_enable} = 2'b00;
        i_enable = 1'b0;
        wr16(4'ha, 16'hfff0);
        wr(4'h6, 8'h03);
        wr(4'h5, 8'h02);
        i_enable = 1'b1;
        for (int n = 0; n < 40 && o_wrap_event !== 1'b1; n++) tick();
        chk(o_wrap_event, 16'h0001);
        rd(4'h6, b);
        chk(b[1], 16'h0001);
        chk(o_interrupt_request, 16'h0001);
        wr(4'h5, 8'h00);
        chk(o_interrupt_request, 16'h0000);
        wr(4'h6, 8'h02);
        rd(4'h6, b);
        chk(b[1], 16'h0000);
        final_report();
    end
    // whole run needs about two thousand cycles
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        err_count++;
        final_report();
    end
endmodule
bind timer_capture timer_capture_props timer_capture_props_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .o_interrupt_request(o_interrupt_request), .o_wrap_event(o_wrap_event));
